// >>> inc/spbc_pkg.sv
`default_nettype none
package spbc_pkg;
  localparam logic [7:0] SPBC_ADDR_VEHT   = 8'h46;
  localparam logic [7:0] SPBC_ADDR_SYNC   = 8'h50;
  localparam logic [7:0] SPBC_ADDR_VERTICAL_BLANK_LENGTH = 8'h51;
  localparam logic [7:0] SPBC_RST_VEHT    = 8'h00;
  localparam logic [7:0] SPBC_RST_SYNC    = 8'h20;
  localparam logic [7:0] SPBC_RST_VERTICAL_BLANK_LENGTH  = 8'h00;
  localparam logic [7:0] SPBC_SYNC_USED   = 8'h3f;
  localparam int unsigned SPBC_BIT_HORIZONTAL_SYNC_POLARITY = 0;
  localparam int unsigned SPBC_BIT_VERTICAL_SYNC_POLARITY = 1;
  localparam int unsigned SPBC_BIT_SERVICE_LINE_SELECT = 2;
  localparam int unsigned SPBC_BIT_V1D  = 3;
  localparam int unsigned SPBC_BIT_V2D  = 4;
  localparam int unsigned SPBC_BIT_VPD  = 5;
  // Bus address of the slave; value is arbitrary
  localparam logic [6:0] SPBC_DEV_ADDR = 7'h2a;
  localparam int unsigned SPBC_PROT_LINES = 1024;
  localparam logic [3:0] SPBC_BYTE_BITS = 4'h8;
endpackage
`default_nettype wire

// >>> inc/spbc_reg_if.sv
`default_nettype none
interface spbc_reg_if;
  logic       wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus  (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> hw/spbc_i2c_slave.sv
`default_nettype none
module spbc_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = spbc_pkg::SPBC_DEV_ADDR
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic ce,
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  output var  logic sda_out,
  output var  logic sda_oe,
  spbc_reg_if.bus   rb
);
  import spbc_pkg::*;

  typedef enum logic [3:0] {
    I_IDLE, I_DEV, I_DEV_ACK, I_SUB, I_SUB_ACK, I_WR, I_WR_ACK, I_RD, I_RD_ACK, I_RD_NEXT
  } spbc_i2c_e;

  logic [2:0] scl_q;
  logic [2:0] sda_q;
  spbc_i2c_e  state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic [7:0] ptr, next_ptr;
  logic       rw, next_rw;
  logic       next_oe;
  logic       next_wr;
  logic       scl_rise, scl_fall, start, stop, sda_bit;

  // Stage 0 feeds only stage 1; edges are taken from stages 1 and 2
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end
    else if (ce)
    begin
      scl_q <= {scl_q[1:0], scl_pin};
      sda_q <= {sda_q[1:0], sda_pin};
    end
  end

  assign sda_bit  = sda_q[1];
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start    = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop     = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  assign rb.addr  = ptr;
  assign rb.wdata = sh;

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_sh    = sh;
    next_ptr   = ptr;
    next_rw    = rw;
    next_oe    = sda_oe;
    next_wr    = 1'b0;
    if (start)
    begin
      next_state = I_DEV;
      next_cnt   = 4'h0;
      next_oe    = 1'b0;
    end
    else if (stop)
    begin
      next_state = I_IDLE;
      next_oe    = 1'b0;
    end
    else if (scl_rise)
    begin
      unique case (state)
        I_DEV, I_SUB, I_WR:
        begin
          next_sh  = {sh[6:0], sda_bit};
          next_cnt = cnt + 4'h1;
        end
        I_RD: next_cnt = cnt + 4'h1;
        // Master not acknowledging ends the read burst
        I_RD_ACK: next_state = sda_bit ? I_IDLE : I_RD_NEXT;
        I_IDLE, I_DEV_ACK, I_SUB_ACK, I_WR_ACK, I_RD_NEXT: ;
      endcase
    end
    else if (scl_fall)
    begin
      unique case (state)
        I_DEV:
          if (cnt == SPBC_BYTE_BITS)
          begin
            if (sh[7:1] == DEV_ADDR)
            begin
              next_state = I_DEV_ACK;
              next_oe    = 1'b1;
              next_rw    = sh[0];
            end
            else
              next_state = I_IDLE;
          end
        I_DEV_ACK, I_RD_NEXT:
        begin
          next_cnt = 4'h0;
          if (rw)
          begin
            next_sh    = rb.rdata;
            next_oe    = ~rb.rdata[7];
            next_state = I_RD;
          end
          else
          begin
            next_oe    = 1'b0;
            next_state = I_SUB;
          end
        end
        I_SUB:
          if (cnt == SPBC_BYTE_BITS)
          begin
            next_ptr   = sh;
            next_oe    = 1'b1;
            next_state = I_SUB_ACK;
          end
        I_SUB_ACK, I_WR_ACK:
        begin
          next_oe    = 1'b0;
          next_cnt   = 4'h0;
          next_state = I_WR;
          if (state == I_WR_ACK)
            next_ptr = ptr + 8'h01;
        end
        I_WR:
          if (cnt == SPBC_BYTE_BITS)
          begin
            next_wr    = 1'b1;
            next_oe    = 1'b1;
            next_state = I_WR_ACK;
          end
        I_RD:
          if (cnt == SPBC_BYTE_BITS)
          begin
            next_oe    = 1'b0;
            next_ptr   = ptr + 8'h01;
            next_state = I_RD_ACK;
          end
          else
          begin
            next_sh = {sh[6:0], 1'b0};
            next_oe = ~sh[6];
          end
        I_IDLE, I_RD_ACK: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state     <= I_IDLE;
      cnt       <= 4'h0;
      sh        <= 8'h00;
      ptr       <= 8'h00;
      rw        <= 1'b0;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
      rb.wr_stb <= 1'b0;
    end
    else if (ce)
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      sh        <= next_sh;
      ptr       <= next_ptr;
      rw        <= next_rw;
      sda_oe    <= next_oe;
      sda_out   <= 1'b0;
      rb.wr_stb <= next_wr;
    end
  end
endmodule
`default_nettype wire

// >>> hw/spbc_top.sv
// Notes on behaviour
// - Vertical protect disable resets to 1, and protection works only once it is cleared.
// - With protection disabled a missing flyback never blanks the RGB outputs.
// - East-west EHT correction passes when its disable bit is 0 and is zero when 1.
// - Vertical drive EHT correction passes when its disable bit is 0 and is zero when 1.
// - Service bit 1 holds the vertical ramp at its DC reference, 0 lets it run.
// - Vertical polarity 0 takes falling edges as sync, 1 takes rising edges.
// - Horizontal polarity 0 takes falling edges as sync, 1 takes rising edges.
// - Vertical blanking lasts the programmed number of lines, counted on horizontal sync.
// - The EHT register's upper nibble is east-west and lower nibble vertical drive.
`default_nettype none
module spbc_top #(
  parameter logic [6:0]  DEV_ADDR   = spbc_pkg::SPBC_DEV_ADDR,
  parameter int unsigned PROT_LINES = spbc_pkg::SPBC_PROT_LINES
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       scl_pin,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  input  wire logic       hsync_pin,
  input  wire logic       vsync_pin,
  input  wire logic       vflyback_pin,
  output var  logic       hsync_pulse,
  output var  logic       vsync_pulse,
  output var  logic       vertical_blank_length_out,
  output var  logic       rgb_blank,
  output var  logic       vert_protect_en,
  output var  logic       vert_ramp_hold,
  output var  logic [3:0] ew_eht_amount,
  output var  logic [3:0] vd_eht_amount
);
  import spbc_pkg::*;

  if (PROT_LINES < 2 || PROT_LINES > 65535)
  begin : g_bad_prot
    $error("PROT_LINES must lie in 2..65535");
  end

  localparam logic [15:0] PROT_MAX = 16'(PROT_LINES);

  spbc_reg_if rb ();

  spbc_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .clock   (clock),
    .arst_n  (arst_n),
    .ce      (ce),
    .scl_pin (scl_pin),
    .sda_pin (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .rb      (rb)
  );

  // Register file
  logic [7:0] sync_polarity_control, next_sync;
  logic [7:0] vertical_blank_length, next_vertical_blank_length_len;
  logic [7:0] vertical_eht_correction, next_veht;

  always_comb
  begin
    next_sync       = sync_polarity_control;
    next_vertical_blank_length_len = vertical_blank_length;
    next_veht       = vertical_eht_correction;
    if (rb.wr_stb)
    begin
      case (rb.addr)
        SPBC_ADDR_SYNC:   next_sync = rb.wdata & SPBC_SYNC_USED;
        SPBC_ADDR_VERTICAL_BLANK_LENGTH: next_vertical_blank_length_len = rb.wdata;
        SPBC_ADDR_VEHT:   next_veht = rb.wdata;
        // Unmapped addresses are acknowledged but dropped
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (rb.addr)
      SPBC_ADDR_SYNC:   rb.rdata = sync_polarity_control;
      SPBC_ADDR_VERTICAL_BLANK_LENGTH: rb.rdata = vertical_blank_length;
      SPBC_ADDR_VEHT:   rb.rdata = vertical_eht_correction;
      default:          rb.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_polarity_control   <= SPBC_RST_SYNC;
      vertical_blank_length   <= SPBC_RST_VERTICAL_BLANK_LENGTH;
      vertical_eht_correction <= SPBC_RST_VEHT;
    end
    else if (ce)
    begin
      sync_polarity_control   <= next_sync;
      vertical_blank_length   <= next_vertical_blank_length_len;
      vertical_eht_correction <= next_veht;
    end
  end

  logic vertical_protect_disable, v2d, v1d, service_line_select, vertical_sync_polarity, horizontal_sync_polarity;
  assign vertical_protect_disable  = sync_polarity_control[SPBC_BIT_VPD];
  assign v2d  = sync_polarity_control[SPBC_BIT_V2D];
  assign v1d  = sync_polarity_control[SPBC_BIT_V1D];
  assign service_line_select = sync_polarity_control[SPBC_BIT_SERVICE_LINE_SELECT];
  assign vertical_sync_polarity = sync_polarity_control[SPBC_BIT_VERTICAL_SYNC_POLARITY];
  assign horizontal_sync_polarity = sync_polarity_control[SPBC_BIT_HORIZONTAL_SYNC_POLARITY];

  // Pin synchronisers: hsync, vsync, flyback
  logic [2:0] pin_raw;
  logic [2:0] pin_meta;
  logic [2:0] pin_s;
  assign pin_raw = {vflyback_pin, vsync_pin, hsync_pin};

  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
      begin
        pin_meta[i] <= 1'b0;
        pin_s[i]    <= 1'b0;
      end
      else if (ce)
      begin
        pin_meta[i] <= pin_raw[i];
        pin_s[i]    <= pin_meta[i];
      end
    end
  end

  // Active level after polarity; a polarity change may give one stray edge
  logic h_lvl, v_lvl, h_lvl_d, v_lvl_d, f_lvl_d;
  logic h_edge, v_edge, f_edge;
  assign h_lvl  = pin_s[0] ^ ~horizontal_sync_polarity;
  assign v_lvl  = pin_s[1] ^ ~vertical_sync_polarity;
  assign h_edge = h_lvl & ~h_lvl_d;
  assign v_edge = v_lvl & ~v_lvl_d;
  assign f_edge = pin_s[2] & ~f_lvl_d;

  logic [7:0]  blank_cnt, next_blank_cnt;
  logic [15:0] line_cnt, next_line_cnt;
  logic        next_fault;

  always_comb
  begin
    next_blank_cnt = blank_cnt;
    // Vertical sync restarts blanking even mid-count
    if (v_edge)
      next_blank_cnt = vertical_blank_length;
    else if (h_edge && blank_cnt != 8'h00)
      next_blank_cnt = blank_cnt - 8'h01;
  end

  always_comb
  begin
    next_line_cnt = line_cnt;
    if (vertical_protect_disable || f_edge)
      next_line_cnt = 16'h0000;
    else if (h_edge && line_cnt != PROT_MAX)
      next_line_cnt = line_cnt + 16'h0001;
    // Blank only once protection is on and flyback went missing
    next_fault = !vertical_protect_disable && next_line_cnt == PROT_MAX;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Reset matches the level seen while the pin stages are cleared, so no false sync edge
      h_lvl_d         <= 1'b1;
      v_lvl_d         <= 1'b1;
      f_lvl_d         <= 1'b0;
      blank_cnt       <= 8'h00;
      line_cnt        <= 16'h0000;
      hsync_pulse     <= 1'b0;
      vsync_pulse     <= 1'b0;
      vertical_blank_length_out      <= 1'b0;
      rgb_blank       <= 1'b0;
      vert_protect_en <= 1'b0;
      vert_ramp_hold  <= 1'b0;
      ew_eht_amount   <= 4'h0;
      vd_eht_amount   <= 4'h0;
    end
    else if (ce)
    begin
      h_lvl_d         <= h_lvl;
      v_lvl_d         <= v_lvl;
      f_lvl_d         <= pin_s[2];
      blank_cnt       <= next_blank_cnt;
      line_cnt        <= next_line_cnt;
      hsync_pulse     <= h_edge;
      vsync_pulse     <= v_edge;
      vertical_blank_length_out      <= next_blank_cnt != 8'h00;
      rgb_blank       <= next_fault;
      vert_protect_en <= ~vertical_protect_disable;
      vert_ramp_hold  <= service_line_select;
      ew_eht_amount   <= v2d ? 4'h0 : vertical_eht_correction[7:4];
      vd_eht_amount   <= v1d ? 4'h0 : vertical_eht_correction[3:0];
    end
  end
endmodule
`default_nettype wire

// >>> bench/spbc_assertions.sv
`default_nettype none
module spbc_assertions (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_pin,
  input wire logic sda_oe,
  input wire logic hsync_pulse,
  input wire logic vsync_pulse,
  input wire logic vertical_blank_length_out,
  input wire logic rgb_blank,
  input wire logic vert_protect_en
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  sequence s_quiet;
    !hsync_pulse && !vsync_pulse;
  endsequence
  sequence s_line;
    hsync_pulse || vsync_pulse;
  endsequence
  a_hpulse_single: assert property (hsync_pulse |=> !hsync_pulse)
    else $error("hsync pulse longer than one cycle");
  a_vpulse_single: assert property (vsync_pulse |=> !vsync_pulse)
    else $error("vsync pulse longer than one cycle");
  a_blank_start: assert property ($rose(vertical_blank_length_out) |-> vsync_pulse)
    else $error("blanking began without vsync");
  a_blank_end: assert property ($fell(vertical_blank_length_out) |-> s_line)
    else $error("blanking ended without a sync pulse");
  a_blank_hold: assert property (vertical_blank_length_out ##1 s_quiet |-> vertical_blank_length_out)
    else $error("blanking dropped between lines");
  a_rgb_prot_off: assert property (!vert_protect_en [*2] |-> !rgb_blank)
    else $error("rgb blanked with protection off");
  a_rgb_on_line: assert property ($rose(rgb_blank) |->
    hsync_pulse || $past(hsync_pulse) || $past(hsync_pulse, 2))
    else $error("rgb blank rose away from a line");
  // Open-drain answer must only move while SCL is low
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_pin)
    else $error("sda moved while scl high");
endmodule
bind spbc_top spbc_assertions u_chk (.clock, .arst_n, .scl_pin, .sda_oe, .hsync_pulse,
  .vsync_pulse, .vertical_blank_length_out, .rgb_blank, .vert_protect_en);
`default_nettype wire

// >>> bench/spbc_host.sv
`default_nettype none
module spbc_host (
  input  wire logic clock,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  int hcyc = 6;
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic hw();
    repeat (hcyc) @(posedge clock);
    #1;
  endtask
  task automatic start();
    sda_pull = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    sda_pull = 1'b1;
    hw();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    sda_pull = 1'b0;
    hw();
  endtask
  // Data moves mid-low so no edge can pass for a start or stop
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      hw();
      sda_pull = !d[i];
      hw();
      scl = 1'b1;
      hw();
      q[i] = sda;
      scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
`default_nettype none
module tb;
  import spbc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] pins = 3'b011;
  logic       scl, pull, sda_out, sda_oe, hsync_pulse, vsync_pulse;
  logic       vertical_blank_length_out, rgb_blank, vert_protect_en, vert_ramp_hold;
  logic [3:0] ew_eht_amount, vd_eht_amount;
  logic [8:0] q;
  logic [7:0] tv [6] = '{8'hc0, 8'h10, 8'h08, 8'h04, 8'h3f, 8'h20};
  int         nh, nv, n_fail, samples_checked;
  wire        sda = !((sda_oe && !sda_out) || pull);
  always #2.5 clock = ~clock;
  spbc_host host (.clock, .sda, .scl, .sda_pull(pull));
  spbc_top #(.PROT_LINES(4)) dut (.clock, .arst_n, .ce(1'b1), .scl_pin(scl), .sda_in(sda),
    .sda_out, .sda_oe, .hsync_pin(pins[0]), .vsync_pin(pins[1]), .vflyback_pin(pins[2]),
    .hsync_pulse, .vsync_pulse, .vertical_blank_length_out, .rgb_blank, .vert_protect_en,
    .vert_ramp_hold, .ew_eht_amount, .vd_eht_amount);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] b [3];
    b = '{{SPBC_DEV_ADDR, 1'b0}, a, d};
    host.start();
    foreach (b[i])
    begin
      host.xfer({b[i], 1'b1}, q);
      chk(8'(q[0]), 8'h00);
    end
    host.stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.start();
    host.xfer({SPBC_DEV_ADDR, 2'b01}, q);
    host.xfer({a, 1'b1}, q);
    host.start();
    host.xfer({SPBC_DEV_ADDR, 2'b11}, q);
    chk(8'(q[0]), 8'h00);
    host.xfer(9'h1ff, q);
    chk(q[8:1], exp);
    host.stop();
  endtask
  task automatic pin(input int k, input logic v);
    pins[k] = v;
    nh = 0;
    nv = 0;
    repeat (12)
    begin
      @(posedge clock);
      #1;
      nh += hsync_pulse;
      nv += vsync_pulse;
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clock);
    $display("Error at %0t: timeout", $time);
    n_fail++;
    stop_test();
  end
  initial
  begin
    repeat (5) @(posedge clock);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk(8'(vert_protect_en), 8'h00);
    rd(SPBC_ADDR_SYNC, SPBC_RST_SYNC);
    repeat (6)
    begin
      pin(0, 1'b0);
      pin(0, 1'b1);
    end
    chk(8'(rgb_blank), 8'h00);
    wr(SPBC_ADDR_VEHT, 8'ha5);
    // Ends on 0x20 so polarity settles before protection counts lines
    foreach (tv[i])
    begin
      wr(SPBC_ADDR_SYNC, tv[i]);
      rd(SPBC_ADDR_SYNC, tv[i] & SPBC_SYNC_USED);
      chk({ew_eht_amount, vd_eht_amount}, {tv[i][4] ? 4'h0 : 4'ha, tv[i][3] ? 4'h0 : 4'h5});
      chk({vert_protect_en, vert_ramp_hold}, {!tv[i][5], tv[i][2]});
    end
    wr(SPBC_ADDR_SYNC, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      chk(8'(rgb_blank), 8'h00);
      pin(0, 1'b0);
      pin(0, 1'b1);
    end
    chk(8'(rgb_blank), 8'h01);
    pin(2, 1'b1);
    chk(8'(rgb_blank), 8'h00);
    pin(2, 1'b0);
    for (int p = 0; p < 2; p++)
    begin
      wr(SPBC_ADDR_SYNC, {6'h08, p[0], p[0]});
      for (int k = 0; k < 2; k++)
      begin
        pin(k, 1'b0);
        chk(8'(k ? nv : nh), 8'(p == 0));
        pin(k, 1'b1);
        chk(8'(k ? nv : nh), 8'(p));
      end
    end
    wr(SPBC_ADDR_SYNC, 8'h20);
    wr(SPBC_ADDR_VERTICAL_BLANK_LENGTH, 8'h03);
    rd(SPBC_ADDR_VERTICAL_BLANK_LENGTH, 8'h03);
    pin(1, 1'b0);
    pin(1, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      chk(8'(vertical_blank_length_out), 8'h01);
      pin(0, 1'b0);
      pin(0, 1'b1);
    end
    chk(8'(vertical_blank_length_out), 8'h00);
    wr(SPBC_ADDR_VERTICAL_BLANK_LENGTH, 8'h00);
    pin(1, 1'b0);
    chk(8'(vertical_blank_length_out), 8'h00);
    pin(1, 1'b1);
    rd(8'h52, 8'h00);
    host.start();
    host.xfer({SPBC_DEV_ADDR ^ 7'h01, 2'b01}, q);
    chk(8'(q[0]), 8'h01);
    host.stop();
    host.hcyc = 20;
    rd(SPBC_ADDR_VEHT, 8'ha5);
    stop_test();
  end
endmodule
`default_nettype wire
